// file: tsa_pkg.sv
// package for the temperature sensor alarm core: register indices, fields,
// reset values, timing constants and the carrier structs.
// assumes a 200 MHz core clock and a serial front end on the same clock.
package tsa_pkg;

    // pointer values selecting the six data registers
    localparam logic [2:0] TSA_PTR_TEMP  = 3'h0;
    localparam logic [2:0] TSA_PTR_CFG   = 3'h1;
    localparam logic [2:0] TSA_PTR_HYST  = 3'h2;
    localparam logic [2:0] TSA_PTR_CRIT  = 3'h3;
    localparam logic [2:0] TSA_PTR_LOW   = 3'h4;
    localparam logic [2:0] TSA_PTR_HIGH  = 3'h5;

    // reset values
    localparam logic [15:0] TSA_RST_TEMP = 16'h0000;
    localparam logic [7:0]  TSA_RST_CFG  = 8'h00;
    localparam logic [15:0] TSA_RST_HYST = 16'h0100;
    localparam logic [15:0] TSA_RST_CRIT = 16'h2800;
    localparam logic [15:0] TSA_RST_LOW  = 16'h0500;
    localparam logic [15:0] TSA_RST_HIGH = 16'h2000;

    // configuration field positions
    localparam int TSA_CFG_SHDN   = 0;
    localparam int TSA_CFG_INTM   = 1;
    localparam int TSA_CFG_OTPOL  = 2;
    localparam int TSA_CFG_ALPOL  = 3;
    localparam int TSA_CFG_FQEN   = 4;
    localparam int TSA_CFG_TODIS  = 5;
    localparam logic [7:0] TSA_CFG_WMASK = 8'h3F;

    // temperature result layout: flags in the three lowest bits
    localparam int TSA_FLAG_CRIT  = 2;
    localparam int TSA_FLAG_HIGH  = 1;
    localparam int TSA_FLAG_LOW   = 0;
    localparam logic [15:0] TSA_DATA_MASK = 16'hFFF8;

    // fault queue depths
    localparam logic [2:0] TSA_DEPTH_1 = 3'h1;
    localparam logic [2:0] TSA_DEPTH_4 = 3'h4;

    // conversion period
    localparam longint TSA_CLK_HZ     = 200000000;
    localparam longint TSA_CONV_MS    = 500;
    localparam longint TSA_CONV_CYC   = (TSA_CLK_HZ * TSA_CONV_MS) / 1000;

    // register access request from the serial front end
    typedef struct packed {
        logic        ptr_wr;
        logic [2:0]  ptr;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } tsa_req_t;

    // conversion result from the analog side
    typedef struct packed {
        logic        valid;
        logic [12:0] code;
    } tsa_adc_t;

endpackage

// file: tsa_regfile.sv
// small register store for the limit and hysteresis words.
// assumes one writer and registered read data, all on one clock.
`timescale 1ns/1ps
module tsa_regfile
    import tsa_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic        wr_i,
    input  wire logic [1:0]  waddr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic [1:0]  raddr_i,
    output logic      [15:0] rdata_o,
    output logic      [15:0] hyst_o,
    output logic      [15:0] crit_o,
    output logic      [15:0] low_o,
    output logic      [15:0] high_o
);
    logic [15:0] mem_reg [4];
    logic [15:0] rdata_reg;

    // entries reset to their documented power-on values
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            mem_reg[0] <= TSA_RST_HYST;
            mem_reg[1] <= TSA_RST_CRIT;
            mem_reg[2] <= TSA_RST_LOW;
            mem_reg[3] <= TSA_RST_HIGH;
            rdata_reg  <= 16'h0000;
        end
        else
        begin
            if (wr_i)
                mem_reg[waddr_i] <= wdata_i;
            rdata_reg <= mem_reg[raddr_i];
        end
    end

    assign rdata_o = rdata_reg;
    assign hyst_o  = mem_reg[0];
    assign crit_o  = mem_reg[1];
    assign low_o   = mem_reg[2];
    assign high_o  = mem_reg[3];
endmodule

// file: tsa_core.sv
// temperature sensor alarm core: pointer-selected registers, result
// register with flags, conversion pacing, fault queues and alarm pins.
// assumes the serial front end decodes frames and runs on mclk_i; the
// adc result strobe arrives from another domain as a toggle of the valid flag.
`timescale 1ns/1ps
module tsa_core
    import tsa_pkg::*;
#(
    parameter longint CONV_CYC = TSA_CONV_CYC
)
(
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire tsa_pkg::tsa_req_t req_i,
    input  wire tsa_pkg::tsa_adc_t adc_i,
    output logic      [15:0] rdata_o,
    output logic             conv_start_o,
    output logic             conv_abort_o,
    output logic             bus_timeout_en_o,
    output logic             alert_out_o,
    output logic             alert_oe_o,
    output logic             overtemp_out_o,
    output logic             overtemp_oe_o
);
    import tsa_pkg::*;

    typedef enum logic [1:0]
    {
        TSA_IDLE = 2'b01,
        TSA_CONV = 2'b10
    } tsa_state_t;

    tsa_state_t  state_reg, state_next;
    logic [2:0]  ptr_reg;
    logic [7:0]  cfg_reg;
    logic [15:0] temp_reg;
    logic [31:0] tick_reg;
    logic        adc_s1_reg, adc_s2_reg, adc_s3_reg;
    logic [12:0] code_reg;
    logic [2:0]  al_cnt_reg, ot_cnt_reg;
    logic        al_act_reg, ot_act_reg;
    logic        al_arm_hi_reg;
    logic        al_low_reg;
    logic        rd_d_reg;
    logic        al_out_reg, ot_out_reg, al_oe_reg, ot_oe_reg;
    logic [15:0] rdata_reg;
    logic        start_reg, abort_reg;

    wire [15:0] hyst_w, crit_w, low_w, high_w, rf_rdata;
    wire        rf_wr;
    wire [1:0]  rf_waddr;
    wire [1:0]  rf_raddr;

    // limits and hysteresis live in the small store
    tsa_regfile u_rf
    (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .wr_i      (rf_wr),
        .waddr_i   (rf_waddr),
        .wdata_i   (req_i.wdata),
        .raddr_i   (rf_raddr),
        .rdata_o   (rf_rdata),
        .hyst_o    (hyst_w),
        .crit_o    (crit_w),
        .low_o     (low_w),
        .high_o    (high_w)
    );

    wire [2:0] sel      = req_i.ptr_wr ? req_i.ptr : ptr_reg;
    wire       rf_hit   = (sel >= TSA_PTR_HYST) && (sel <= TSA_PTR_HIGH);
    wire [2:0] sel_off  = sel - TSA_PTR_HYST;
    assign rf_wr    = req_i.wr && rf_hit;
    assign rf_waddr = sel_off[1:0];
    assign rf_raddr = sel_off[1:0];
    wire       cfg_wr   = req_i.wr && (sel == TSA_PTR_CFG);
    wire       temp_rd  = req_i.rd && (sel == TSA_PTR_TEMP);
    wire       any_rd   = req_i.rd;

    wire shdn   = cfg_reg[TSA_CFG_SHDN];
    wire intm   = cfg_reg[TSA_CFG_INTM];
    wire ot_pol = cfg_reg[TSA_CFG_OTPOL];
    wire al_pol = cfg_reg[TSA_CFG_ALPOL];
    wire [2:0] depth = cfg_reg[TSA_CFG_FQEN] ? TSA_DEPTH_4 : TSA_DEPTH_1;

    // sign-extended comparisons in the result format
    wire signed [16:0] t_s   = {code_reg[12], code_reg, 3'h0};
    wire signed [16:0] hi_s  = {high_w[15], high_w[15:3], 3'h0};
    wire signed [16:0] lo_s  = {low_w[15], low_w[15:3], 3'h0};
    wire signed [16:0] cr_s  = {crit_w[15], crit_w[15:3], 3'h0};
    wire signed [16:0] hy_s  = {hyst_w[15], hyst_w[15:3], 3'h0};
    wire over_hi  = t_s > hi_s;
    wire under_lo = t_s < lo_s;
    wire over_cr  = t_s > cr_s;
    wire rel_hi   = t_s < (hi_s - hy_s);
    wire rel_lo   = t_s > (lo_s + hy_s);
    wire rel_cr   = t_s < (cr_s - hy_s);

    // alert condition: fault while idle, release while active
    wire al_fault = al_arm_hi_reg ? rel_hi : (over_hi || under_lo);
    // release watches only the side that raised the alarm, else a high
    // alarm would drop at once because the reading sits above low plus hyst
    wire al_rel   = al_low_reg ? rel_lo : rel_hi;
    wire al_cond  = al_act_reg ? al_rel : al_fault;
    wire ot_cond  = ot_act_reg ? rel_cr : over_cr;

    // adc result strobe sync: stage one feeds stage two only
    wire adc_new = adc_s2_reg ^ adc_s3_reg;

    // pointer and configuration writes
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ptr_reg <= TSA_PTR_TEMP;
            cfg_reg <= TSA_RST_CFG;
        end
        else
        begin
            if (req_i.ptr_wr)
                ptr_reg <= req_i.ptr;
            // configuration write, reserved bits held zero
            if (cfg_wr)
                cfg_reg <= req_i.wdata[7:0] & TSA_CFG_WMASK;
        end
    end

    // conversion pacing state machine
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            TSA_IDLE:
                if (!shdn && tick_reg == 32'h0)
                    state_next = TSA_CONV;
            // a tick while busy restarts the conversion so pacing never stalls
            TSA_CONV:
                if (shdn || temp_rd || (adc_new && tick_reg != 32'h0))
                    state_next = TSA_IDLE;
        endcase
    end

    // pacing, abort on temperature read, stop in shutdown
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= TSA_IDLE;
            tick_reg  <= 32'h0;
            start_reg <= 1'b0;
            abort_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            start_reg <= (state_next == TSA_CONV) && (tick_reg == 32'h0) && !shdn;
            abort_reg <= (state_reg == TSA_CONV) && (shdn || temp_rd) && !adc_new;
            if (shdn)
                tick_reg <= 32'h0;
            else if (tick_reg == 32'(CONV_CYC - 1))
                tick_reg <= 32'h0;
            else
                tick_reg <= tick_reg + 32'h1;
        end
    end

    // result strobe synchroniser and capture
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            adc_s1_reg <= 1'b0;
            adc_s2_reg <= 1'b0;
            adc_s3_reg <= 1'b0;
            code_reg   <= 13'h0000;
        end
        else
        begin
            adc_s1_reg <= adc_i.valid;
            adc_s2_reg <= adc_s1_reg;
            adc_s3_reg <= adc_s2_reg;
            if (adc_new && state_reg == TSA_CONV && !temp_rd)
                code_reg <= adc_i.code;
        end
    end
    wire result_done = adc_new && state_reg == TSA_CONV && !temp_rd;
    logic done_d_reg;
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            done_d_reg <= 1'b0;
        else
            done_d_reg <= result_done;
    end

    // result word, flag bits stored as zero, kept through shutdown
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            temp_reg <= TSA_RST_TEMP;
        else if (done_d_reg)
            temp_reg <= {code_reg, 3'h0};
    end

    // alert queue and state; compare runs the cycle after a result lands
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            al_cnt_reg    <= 3'h0;
            al_act_reg    <= 1'b0;
            al_arm_hi_reg <= 1'b0;
            al_low_reg    <= 1'b0;
        end
        else if (shdn)
            al_cnt_reg <= 3'h0;
        else
        begin
            // interrupt cleared by any read, rearm on hysteresis
            if (intm && al_act_reg && any_rd)
            begin
                al_act_reg    <= 1'b0;
                al_arm_hi_reg <= over_hi;
                al_cnt_reg    <= 3'h0;
            end
            else if (done_d_reg)
            begin
                if (al_cond)
                begin
                    if (al_cnt_reg + 3'h1 >= depth)
                    begin
                        al_act_reg <= intm ? 1'b1 : !al_act_reg;
                        al_cnt_reg <= 3'h0;
                        if (!al_act_reg)
                        begin
                            al_arm_hi_reg <= 1'b0;
                            al_low_reg    <= under_lo;
                        end
                    end
                    else
                        al_cnt_reg <= al_cnt_reg + 3'h1;
                end
                else
                    al_cnt_reg <= 3'h0;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ot_cnt_reg <= 3'h0;
            ot_act_reg <= 1'b0;
        end
        else if (shdn)
            ot_cnt_reg <= 3'h0;
        else if (done_d_reg)
        begin
            if (ot_cond)
            begin
                if (ot_cnt_reg + 3'h1 >= depth)
                begin
                    ot_act_reg <= !ot_act_reg;
                    ot_cnt_reg <= 3'h0;
                end
                else
                    ot_cnt_reg <= ot_cnt_reg + 3'h1;
            end
            else
                ot_cnt_reg <= 3'h0;
        end
    end

    // open-drain pins with polarity, frozen in shutdown
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            al_out_reg <= 1'b0;
            al_oe_reg  <= 1'b0;
            ot_out_reg <= 1'b0;
            ot_oe_reg  <= 1'b0;
        end
        else
        begin
            al_out_reg <= 1'b0;
            ot_out_reg <= 1'b0;
            if (!shdn)
            begin
                // pin pulls low when the level to show is low
                al_oe_reg <= !(al_act_reg ~^ al_pol);
                ot_oe_reg <= !(ot_act_reg ~^ ot_pol);
            end
        end
    end

    // read data mux, registered
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rdata_reg <= 16'h0000;
        else if (req_i.rd)
            // flags are the live alarm states beside the stored result
            rdata_reg <= (sel == TSA_PTR_TEMP) ? {temp_reg[15:3], ot_act_reg,
                                                  al_act_reg && !al_low_reg,
                                                  al_act_reg && al_low_reg} :
                         (sel == TSA_PTR_CFG)  ? {8'h00, cfg_reg} : 16'h0000;
    end
    logic rf_rd_d_reg;
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rf_rd_d_reg <= 1'b0;
            rd_d_reg    <= 1'b0;
        end
        else
        begin
            rf_rd_d_reg <= req_i.rd && rf_hit;
            rd_d_reg    <= req_i.rd;
        end
    end

    logic [15:0] rdata_out_reg;
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rdata_out_reg <= 16'h0000;
        else if (rd_d_reg)
            rdata_out_reg <= rf_rd_d_reg ? rf_rdata : rdata_reg;
    end

    logic tmo_reg;
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            tmo_reg <= 1'b1;
        else
            tmo_reg <= !cfg_reg[TSA_CFG_TODIS];
    end

    assign rdata_o          = rdata_out_reg;
    assign conv_start_o     = start_reg;
    assign conv_abort_o     = abort_reg;
    assign bus_timeout_en_o = tmo_reg;
    assign alert_out_o      = al_out_reg;
    assign alert_oe_o       = al_oe_reg;
    assign overtemp_out_o   = ot_out_reg;
    assign overtemp_oe_o    = ot_oe_reg;
endmodule

// file: tsa_assertions.sv
// checker for the alarm core: watches the top-level ports only
// assumes one clock and requests that load the pointer with each strobe
`timescale 1ns/1ps
module tsa_assertions
    import tsa_pkg::*;
#(
    parameter longint CONV_CYC = TSA_CONV_CYC
)
(
    input wire logic        mclk_i,
    input wire logic        reset_n_i,
    input wire tsa_req_t    req_i,
    input wire tsa_adc_t    adc_i,
    input wire logic [15:0] rdata_o,
    input wire logic        conv_start_o,
    input wire logic        conv_abort_o,
    input wire logic        bus_timeout_en_o,
    input wire logic        alert_out_o,
    input wire logic        alert_oe_o,
    input wire logic        overtemp_out_o,
    input wire logic        overtemp_oe_o
);
    logic       shdn_reg;
    logic       vld_reg;
    logic       busy_reg;
    logic [4:0] quiet_reg;

    // request decodes; a stir is anything that may move an alarm pin
    wire wr_cfg  = req_i.wr && req_i.ptr_wr && (req_i.ptr == TSA_PTR_CFG);
    wire rd_temp = req_i.rd && req_i.ptr_wr && (req_i.ptr == TSA_PTR_TEMP);
    wire stir    = req_i.rd || req_i.wr || (adc_i.valid != vld_reg);

    // shadow of shutdown and a saturating count of quiet cycles
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            shdn_reg  <= 1'b0;
            vld_reg   <= 1'b0;
            quiet_reg <= 5'h00;
            busy_reg  <= 1'b0;
        end
        else
        begin
            // a conversion runs from a start until an abort or a result toggle
            if (conv_start_o)
                busy_reg <= 1'b1;
            else if (conv_abort_o || adc_i.valid != vld_reg)
                busy_reg <= 1'b0;
            if (wr_cfg)
                shdn_reg <= req_i.wdata[TSA_CFG_SHDN];
            vld_reg   <= adc_i.valid;
            quiet_reg <= stir ? 5'h00 : (quiet_reg == 5'h1F ? quiet_reg : quiet_reg + 5'h01);
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    chk_pins_drain_only: assert property (!alert_out_o && !overtemp_out_o)
        else $error("alarm pin data driven high");
    chk_temp_read_abort: assert property (rd_temp && !shdn_reg && (busy_reg || conv_start_o)
        && adc_i.valid == vld_reg |-> ##[1:2] conv_abort_o)
        else $error("temperature read did not abort");
    chk_abort_has_cause: assert property (conv_abort_o |-> $past(req_i.rd) ||
        $past(req_i.rd, 2) || $past(wr_cfg) || $past(wr_cfg, 2))
        else $error("abort without a read or shutdown");
    chk_timeout_follows: assert property ($past(wr_cfg, 2) |->
        bus_timeout_en_o == !$past(req_i.wdata[TSA_CFG_TODIS], 2))
        else $error("timeout enable not from config");
    chk_rdata_holds: assert property (!$past(req_i.rd) && !$past(req_i.rd, 2)
        |-> $stable(rdata_o))
        else $error("read data moved without a read");
    chk_start_gap: assert property (conv_start_o |=> !conv_start_o [*8])
        else $error("conversion starts too close");
    chk_shdn_no_start: assert property (shdn_reg && $past(shdn_reg, 2) |-> !conv_start_o)
        else $error("conversion started in shutdown");
    chk_alert_cause: assert property ($changed(alert_oe_o) |-> quiet_reg < 5'h0A)
        else $error("alert pin moved without cause");
    chk_overtemp_cause: assert property ($changed(overtemp_oe_o) |-> quiet_reg < 5'h0A)
        else $error("overtemp pin moved without cause");
endmodule

// file: tsa_host_model.sv
// host model: register accesses as the serial front end hands them on
// assumes read data answers two cycles after the read is taken
`timescale 1ns/1ps
module tsa_host_model
    import tsa_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic [15:0] rdata_i,
    output tsa_pkg::tsa_req_t req_o
);
    initial req_o = '0;

    // pointer and access in one strobe
    // the pointer loads with every strobe, so no access hits a stale register
    task automatic access(input logic [2:0] ptr, input logic wr,
                          input logic [15:0] wdata, output logic [15:0] rdata);
        @(posedge mclk_i);
        req_o <= '{ptr_wr: 1'b1, ptr: ptr, wr: wr, rd: !wr, wdata: wdata};
        @(posedge mclk_i);
        req_o <= '0;
        repeat (2) @(posedge mclk_i);
        #1;
        rdata = rdata_i;
    endtask
endmodule

// file: tb_top.sv
// self-checking bench for the alarm core with a host model on the request side
// assumes a short conversion period so the pacing is seen in a short run
`timescale 1ns/1ps
module tb_top;
    import tsa_pkg::*;
    localparam longint CONV_CYC = 50;
    typedef struct packed {
        logic [2:0]  ptr;
        logic        wr;
        logic [15:0] wdata;
        logic [15:0] exp;
    } tsa_row_t;

    logic        mclk_i;
    logic        reset_n_i;
    tsa_adc_t    adc;
    tsa_req_t    req;
    logic [15:0] rdata;
    logic [15:0] rd;
    logic        conv_start;
    logic        tmo_en;
    logic        alert_oe;
    logic        ot_oe;
    int          miscompares = 0;
    int          checks = 0;
    int          n;
    // register rows: reset values, read/write, read-only, unmapped, reserved bits
    tsa_row_t rows [14] = '{
        '{TSA_PTR_TEMP, 1'b0, 16'h0000, TSA_RST_TEMP}, '{TSA_PTR_CFG, 1'b0, 16'h0000, 16'h0000},
        '{TSA_PTR_HYST, 1'b0, 16'h0000, TSA_RST_HYST}, '{TSA_PTR_CRIT, 1'b0, 16'h0000, TSA_RST_CRIT},
        '{TSA_PTR_LOW, 1'b0, 16'h0000, TSA_RST_LOW}, '{TSA_PTR_HIGH, 1'b0, 16'h0000, TSA_RST_HIGH},
        '{TSA_PTR_CFG, 1'b1, 16'h00E0, 16'h0020}, '{TSA_PTR_CRIT, 1'b1, 16'hFFFF, 16'hFFFF},
        '{TSA_PTR_CRIT, 1'b1, 16'h1000, 16'h1000}, '{TSA_PTR_HIGH, 1'b1, 16'h0800, 16'h0800},
        '{TSA_PTR_LOW, 1'b1, 16'h0100, 16'h0100}, '{TSA_PTR_TEMP, 1'b1, 16'h5555, 16'h0000},
        '{3'h6, 1'b1, 16'hAAAA, 16'h0000}, '{TSA_PTR_CFG, 1'b1, 16'h0000, 16'h0000}};

    tsa_host_model i_host (.mclk_i(mclk_i), .rdata_i(rdata), .req_o(req));
    tsa_core #(.CONV_CYC(CONV_CYC)) i_dut (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .req_i(req), .adc_i(adc), .rdata_o(rdata),
        .conv_start_o(conv_start), .conv_abort_o(), .bus_timeout_en_o(tmo_en),
        .alert_out_o(), .alert_oe_o(alert_oe), .overtemp_out_o(), .overtemp_oe_o(ot_oe));

    // free-running clock
    always #2.5 mclk_i = ~mclk_i;

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic acc(input logic [2:0] p, input logic w, input logic [15:0] d);
        i_host.access(p, w, d, rd);
    endtask

    // k results per call, each only once a conversion has started; code is set a
    // cycle before the toggle so it is stable
    task automatic conv(input logic [12:0] code, input int k);
        repeat (k)
        begin
            n = 0;
            while (conv_start !== 1'b1 && n < 200)
            begin
                @(posedge mclk_i);
                #1;
                n++;
            end
            check("conv_wait", {15'h0000, conv_start}, 16'h0001);
            @(posedge mclk_i);
            adc.code <= code;
            @(posedge mclk_i);
            adc.valid <= ~adc.valid;
            repeat (8) @(posedge mclk_i);
            #1;
        end
    endtask

    task automatic alarms(input logic a, input logic o);
        check("alert_oe", {15'h0000, alert_oe}, {15'h0000, a});
        check("overtemp_oe", {15'h0000, ot_oe}, {15'h0000, o});
    endtask

    // spacing between two start pulses, bounded so a silent pacer cannot hang
    task automatic period();
        n = 0;
        while (conv_start !== 1'b1 && n < 200)
        begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        n = 0;
        do
        begin
            @(posedge mclk_i);
            #1;
            n++;
        end while (conv_start !== 1'b1 && n < 200);
    endtask

    // watchdog well past the few thousand cycles the sequence needs
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        miscompares++;
        summarize();
    end

    // main sequence
    initial
    begin
        mclk_i = 1'b0;
        reset_n_i = 1'b0;
        adc = '0;
        repeat (3) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        #1;
        check("tmo_en", {15'h0000, tmo_en}, 16'h0001);
        foreach (rows[i])
        begin
            if (rows[i].wr)
                acc(rows[i].ptr, 1'b1, rows[i].wdata);
            acc(rows[i].ptr, 1'b0, 16'h0000);
            check("reg", rd, rows[i].exp);
            if (i == 6)
                check("tmo_en", {15'h0000, tmo_en}, 16'h0000);
        end
        period();
        check("period", 16'(n), 16'(CONV_CYC));
        alarms(1'b0, 1'b0);
        conv(13'h0110, 1);
        alarms(1'b1, 1'b0);
        acc(TSA_PTR_TEMP, 1'b0, 16'h0000);
        check("temp", rd, 16'h0882);
        alarms(1'b1, 1'b0);
        conv(13'h00F0, 1);
        alarms(1'b1, 1'b0);
        conv(13'h00DE, 1);
        alarms(1'b0, 1'b0);
        conv(13'h0210, 1);
        alarms(1'b1, 1'b1);
        acc(TSA_PTR_TEMP, 1'b0, 16'h0000);
        check("temp", rd, 16'h1086);
        conv(13'h01F0, 1);
        alarms(1'b1, 1'b1);
        conv(13'h01D0, 1);
        alarms(1'b1, 1'b0);
        acc(TSA_PTR_CFG, 1'b1, 16'h000C);
        alarms(1'b0, 1'b1);
        acc(TSA_PTR_CFG, 1'b1, 16'h0000);
        conv(13'h0080, 1);
        conv(13'h0010, 1);
        alarms(1'b1, 1'b0);
        acc(TSA_PTR_TEMP, 1'b0, 16'h0000);
        check("temp", rd, 16'h0081);
        conv(13'h0080, 1);
        alarms(1'b0, 1'b0);
        acc(TSA_PTR_CFG, 1'b1, 16'h0010);
        conv(13'h0110, 3);
        conv(13'h0080, 1);
        conv(13'h0110, 3);
        alarms(1'b0, 1'b0);
        conv(13'h0110, 1);
        alarms(1'b1, 1'b0);
        conv(13'h0080, 3);
        alarms(1'b1, 1'b0);
        conv(13'h0080, 1);
        alarms(1'b0, 1'b0);
        conv(13'h0210, 3);
        alarms(1'b0, 1'b0);
        conv(13'h0210, 1);
        alarms(1'b1, 1'b1);
        conv(13'h0080, 4);
        alarms(1'b0, 1'b0);
        acc(TSA_PTR_CFG, 1'b1, 16'h0002);
        conv(13'h0110, 1);
        alarms(1'b1, 1'b0);
        acc(TSA_PTR_CFG, 1'b0, 16'h0000);
        alarms(1'b0, 1'b0);
        conv(13'h0110, 1);
        alarms(1'b0, 1'b0);
        conv(13'h00DE, 1);
        alarms(1'b1, 1'b0);
        acc(TSA_PTR_HYST, 1'b0, 16'h0000);
        alarms(1'b0, 1'b0);
        acc(TSA_PTR_CFG, 1'b1, 16'h0001);
        n = 0;
        repeat (150)
        begin
            @(posedge mclk_i);
            #1;
            if (conv_start === 1'b1)
                n++;
        end
        check("shdn_starts", 16'(n), 16'h0000);
        acc(TSA_PTR_TEMP, 1'b0, 16'h0000);
        check("shdn_temp", rd & TSA_DATA_MASK, 16'h06F0);
        acc(TSA_PTR_CFG, 1'b1, 16'h0000);
        period();
        check("period", 16'(n), 16'(CONV_CYC));
        @(posedge mclk_i);
        reset_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        acc(TSA_PTR_HIGH, 1'b0, 16'h0000);
        check("high", rd, TSA_RST_HIGH);
        alarms(1'b0, 1'b0);
        summarize();
    end
endmodule

bind tsa_core tsa_assertions #(.CONV_CYC(CONV_CYC)) i_chk (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .req_i(req_i), .adc_i(adc_i), .rdata_o(rdata_o),
    .conv_start_o(conv_start_o), .conv_abort_o(conv_abort_o),
    .bus_timeout_en_o(bus_timeout_en_o), .alert_out_o(alert_out_o), .alert_oe_o(alert_oe_o),
    .overtemp_out_o(overtemp_out_o), .overtemp_oe_o(overtemp_oe_o));
